// ===== include/wtg_map.svh
`ifndef WTG_MAP_SVH
`define WTG_MAP_SVH

// ----------------------------------------------------------------
// clocking and tick timing
// ----------------------------------------------------------------
`define WTG_CLOCK_HZ          50000000
`define WTG_TICK_SLOW_MS      10
`define WTG_TICK_FAST_MS      1
`define WTG_TICK_SLOW_CYCLES  ((`WTG_CLOCK_HZ / 1000) * `WTG_TICK_SLOW_MS)
`define WTG_TICK_FAST_CYCLES  ((`WTG_CLOCK_HZ / 1000) * `WTG_TICK_FAST_MS)

// ----------------------------------------------------------------
// rate conversion
// ----------------------------------------------------------------
`define WTG_RATE_NUMERATOR    64000
`define WTG_RATE_WIDTH        18
`define WTG_RATE_RESET        18'h00000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WTG_PERIOD_WIDTH      9
`define WTG_PERIOD_PRE_HI     8
`define WTG_PERIOD_PRE_LO     7
`define WTG_PERIOD_COUNT_HI   6
`define WTG_FIRST_WIDTH       7
`define WTG_FIRST_PRE_BIT     6
`define WTG_FIRST_COUNT_HI    5
`define WTG_SECOND_WIDTH      3

// ----------------------------------------------------------------
// prescaler and delay sizing
// ----------------------------------------------------------------
`define WTG_PRESCALE_STAGE    4'hf
`define WTG_FIRST_PRE_SHIFT   4
`define WTG_DELAY_WIDTH       16

`endif

// ===== include/wtg_pkg.sv
package wtg_pkg;

	// listen sequence, gray coded along idle -> first -> second
	typedef enum logic [1:0] {
		WTG_IDLE   = 2'b00,
		WTG_FIRST  = 2'b01,
		WTG_SECOND = 2'b11
	} wtg_state_type;

	typedef enum logic [1:0] {
		WTG_PRE_1   = 2'b00,
		WTG_PRE_16A = 2'b01,
		WTG_PRE_16B = 2'b10,
		WTG_PRE_256 = 2'b11
	} wtg_prescale_type;

endpackage : wtg_pkg

// ===== include/wtg_delay_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "wtg_map.svh"

interface wtg_delay_if;
	logic                        start;
	logic                        tick;
	logic [`WTG_DELAY_WIDTH-1:0] count;
	logic                        done;

	modport ctrl (output start, output tick, output count, input done);
	modport counter (input start, input tick, input count, output done);
endinterface : wtg_delay_if

`default_nettype wire

// ===== verilog/wtg_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none

module wtg_tick_gen #(
	parameter int CYCLES = 50000
) (
	input  wire logic clock_in,
	input  wire logic arst_n_in,
	output logic      tick_out
);
	localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

	logic [W-1:0] count;

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count    <= '0;
			tick_out <= 1'b0;
		end else if (count == W'(CYCLES - 1)) begin
			count    <= '0;
			tick_out <= 1'b1;
		end else begin
			count    <= count + W'(1);
			tick_out <= 1'b0;
		end
	end

	tick_single_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE3
		(tick_out && CYCLES > 1) |=> !tick_out)
		else $error("tick lasted more than one cycle");

endmodule : wtg_tick_gen

`default_nettype wire

// ===== verilog/wtg_delay_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "wtg_map.svh"

module wtg_delay_counter (
	input  wire logic     clock_in,
	input  wire logic     arst_n_in,
	wtg_delay_if.counter  dly
);
	logic [`WTG_DELAY_WIDTH-1:0] remaining;
	logic                        busy;

	// counts whole ticks; a start while busy reloads
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			remaining <= '0;
			busy      <= 1'b0;
			dly.done  <= 1'b0;
		end else if (dly.start) begin
			remaining <= dly.count;
			busy      <= (dly.count != '0);
			dly.done  <= (dly.count == '0);
		end else if (busy && dly.tick) begin
			remaining <= remaining - `WTG_DELAY_WIDTH'(1);
			busy      <= (remaining != `WTG_DELAY_WIDTH'(1));
			dly.done  <= (remaining == `WTG_DELAY_WIDTH'(1)); // RULE9
		end else begin
			dly.done  <= 1'b0;
		end
	end

	done_on_tick_a: assert property (@(posedge clock_in) disable iff (!arst_n_in) // RULE9
		(dly.done && !$past(dly.start)) |-> $past(dly.tick) && $past(remaining) == `WTG_DELAY_WIDTH'(1))
		else $error("delay ended without its last tick");

endmodule : wtg_delay_counter

`default_nettype wire

// ===== verilog/wtg_wakeup_timing.sv
`timescale 1ns/100ps
`default_nettype none
`include "wtg_map.svh"

// Summary of operation
// [RULE1] bit rate strobe period equals rate code divided by 64000 seconds
// [RULE2] software loads 533, 267, 133, 67 for 1200 to 9600 bit/s
// [RULE3] wake period counts ticks of the internal 10 ms tick
// [RULE4] wake period spans 10 ms to about 325 s, accuracy plus/minus 20 percent
// [RULE5] period bits 8:7 pick prescale 1, 16, 16 or 256 via two /16 stages
// [RULE6] period is vv+1 ticks, or prescale times vv plus one ticks
// [RULE7] first listen delay is timed from the 1 ms tick, 1 ms to 1.024 s
// [RULE8] first delay bit 6 selects divide by 1 or by 16
// [RULE9] first delay equals (vv+1) ms, or 16 times (vv+1) ms
// [RULE10] second delay codes 1-4 give 1-4 times, then 8, 16, 31 times
// [RULE11] code zero gives no second delay; both checks run together
// [RULE12] a reset register write asynchronously clears everything
// [RULE13] period timer restarts on every expiry while enabled
module wtg_wakeup_timing #(
	parameter int CLOCK_HZ         = `WTG_CLOCK_HZ,
	parameter int TICK_SLOW_CYCLES = `WTG_TICK_SLOW_CYCLES,
	parameter int TICK_FAST_CYCLES = `WTG_TICK_FAST_CYCLES
) (
	input  wire logic                          clock_in,
	input  wire logic                          arst_n_in,
	input  wire logic                          reset_write_in,
	input  wire logic                          wake_enable_in,
	input  wire logic [`WTG_RATE_WIDTH-1:0]    wake_rate_register_in,
	input  wire logic [`WTG_PERIOD_WIDTH-1:0]  wake_period_field_in,
	input  wire logic [`WTG_FIRST_WIDTH-1:0]   first_listen_delay_in,
	input  wire logic [`WTG_SECOND_WIDTH-1:0]  second_listen_multiple_in,
	output logic                               rate_strobe_out,
	output logic                               period_expired_out,
	output logic                               first_listen_out,
	output logic                               second_listen_out,
	output logic                               first_done_out,
	output logic                               second_done_out,
	output logic                               simultaneous_check_out
);
	localparam int ACC_W = $clog2(CLOCK_HZ) + 1;

	// ----------------------------------------------------------------
	// reset combining
	// ----------------------------------------------------------------
	logic core_rst_n;

	assign core_rst_n = arst_n_in & ~reset_write_in; // RULE12

	// ----------------------------------------------------------------
	// tick sources
	// ----------------------------------------------------------------
	logic tick_slow;
	logic tick_fast;

	wtg_tick_gen #(.CYCLES(TICK_SLOW_CYCLES)) u_tick_slow (
		.clock_in  (clock_in),
		.arst_n_in (core_rst_n),
		.tick_out  (tick_slow)
	);

	wtg_tick_gen #(.CYCLES(TICK_FAST_CYCLES)) u_tick_fast (
		.clock_in  (clock_in),
		.arst_n_in (core_rst_n),
		.tick_out  (tick_fast)
	);

	// ----------------------------------------------------------------
	// rate code to bit strobe
	// ----------------------------------------------------------------
	logic [ACC_W-1:0]           rate_acc;
	logic [ACC_W-1:0]           next_rate_acc;
	logic                       base_tick;
	logic [`WTG_RATE_WIDTH-1:0] bit_count;

	// phase accumulator makes a 64 kHz base tick from the system clock
	always_comb begin
		next_rate_acc = rate_acc + ACC_W'(`WTG_RATE_NUMERATOR);
		base_tick     = (next_rate_acc >= ACC_W'(CLOCK_HZ));
		if (base_tick) begin
			next_rate_acc = next_rate_acc - ACC_W'(CLOCK_HZ);
		end
	end

	always_ff @(posedge clock_in or negedge core_rst_n) begin
		if (!core_rst_n) begin
			rate_acc <= '0;
		end else begin
			rate_acc <= next_rate_acc;
		end
	end

	// one strobe every code base ticks; code zero stops the strobe
	always_ff @(posedge clock_in or negedge core_rst_n) begin
		if (!core_rst_n) begin
			bit_count       <= `WTG_RATE_RESET;
			rate_strobe_out <= 1'b0;
		end else if (!wake_enable_in || wake_rate_register_in == '0) begin
			bit_count       <= `WTG_RATE_RESET;
			rate_strobe_out <= 1'b0;
		end else if (base_tick && bit_count + `WTG_RATE_WIDTH'(1) >= wake_rate_register_in) begin
			bit_count       <= `WTG_RATE_RESET; // RULE1
			rate_strobe_out <= 1'b1;
		end else begin
			bit_count       <= base_tick ? bit_count + `WTG_RATE_WIDTH'(1) : bit_count;
			rate_strobe_out <= 1'b0;
		end
	end

	rate_on_base_a: assert property (@(posedge clock_in) disable iff (!core_rst_n) // RULE1
		rate_strobe_out |-> $past(base_tick) && $past(wake_rate_register_in) != '0)
		else $error("rate strobe without a base tick");

	// ----------------------------------------------------------------
	// wake period timer
	// ----------------------------------------------------------------
	wtg_pkg::wtg_prescale_type pre_sel;
	logic [3:0]                pre_lo;
	logic [3:0]                pre_hi;
	logic                      pre16_tick;
	logic                      pre256_tick;
	logic                      scaled_tick;
	logic                      period_phase;
	logic [6:0]                period_left;
	logic [6:0]                period_vv;

	assign pre_sel     = wtg_pkg::wtg_prescale_type'(
		wake_period_field_in[`WTG_PERIOD_PRE_HI:`WTG_PERIOD_PRE_LO]);
	assign period_vv   = wake_period_field_in[`WTG_PERIOD_COUNT_HI:0];
	assign pre16_tick  = tick_slow && pre_lo == `WTG_PRESCALE_STAGE;
	assign pre256_tick = pre16_tick && pre_hi == `WTG_PRESCALE_STAGE; // RULE5

	always_comb begin
		case (pre_sel)
			wtg_pkg::WTG_PRE_1:   scaled_tick = tick_slow;
			wtg_pkg::WTG_PRE_16A: scaled_tick = pre16_tick;
			wtg_pkg::WTG_PRE_16B: scaled_tick = pre16_tick;
			wtg_pkg::WTG_PRE_256: scaled_tick = pre256_tick; // RULE5
			default:              scaled_tick = tick_slow;
		endcase
	end

	// two cascaded /16 stages, cleared when the scaled count begins
	always_ff @(posedge clock_in or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pre_lo <= 4'h0;
			pre_hi <= 4'h0;
		end else if (!wake_enable_in || !period_phase) begin
			pre_lo <= 4'h0;
			pre_hi <= 4'h0;
		end else if (tick_slow) begin
			pre_lo <= pre_lo + 4'h1; // RULE5
			pre_hi <= pre16_tick ? pre_hi + 4'h1 : pre_hi;
		end
	end

	// one raw 10 ms tick, then vv scaled ticks: prescale*vv+1 in all
	always_ff @(posedge clock_in or negedge core_rst_n) begin
		if (!core_rst_n) begin
			period_phase       <= 1'b0;
			period_left        <= 7'h00;
			period_expired_out <= 1'b0;
		end else if (!wake_enable_in) begin
			period_phase       <= 1'b0;
			period_left        <= 7'h00;
			period_expired_out <= 1'b0;
		end else if (!period_phase && tick_slow) begin
			period_phase       <= (period_vv != 7'h00); // RULE3
			period_left        <= period_vv; // RULE6
			period_expired_out <= (period_vv == 7'h00); // RULE4
		end else if (period_phase && scaled_tick) begin
			period_phase       <= (period_left != 7'h01); // RULE13
			period_left        <= period_left - 7'h01;
			period_expired_out <= (period_left == 7'h01); // RULE6
		end else begin
			period_expired_out <= 1'b0;
		end
	end

	period_restart_a: assert property (@(posedge clock_in) disable iff (!core_rst_n) // RULE13
		(period_expired_out && wake_enable_in) |-> !period_phase && period_left == 7'h00)
		else $error("period timer did not restart");

	prescale_cascade_a: assert property (@(posedge clock_in) disable iff (!core_rst_n) // RULE5
		(pre_hi != 4'h0 && pre_hi != $past(pre_hi)) |-> $past(tick_slow) && $past(pre_lo) == 4'hf && pre_lo == 4'h0)
		else $error("second stage stepped without the first wrapping");

	period_zero_a: assert property (@(posedge clock_in) disable iff (!core_rst_n) // RULE6
		(wake_enable_in && !period_phase && tick_slow && period_vv == 7'h00) |=> period_expired_out)
		else $error("zero count period not one tick long");

	// ----------------------------------------------------------------
	// listen delay lengths
	// ----------------------------------------------------------------
	logic [10:0]                 first_total;
	logic [4:0]                  multiple;
	logic [`WTG_DELAY_WIDTH-1:0] second_total;

	function automatic logic [4:0] wtg_multiple(input logic [2:0] code);
		case (code)
			3'h0:    wtg_multiple = 5'h00; // RULE11
			3'h1:    wtg_multiple = 5'h01;
			3'h2:    wtg_multiple = 5'h02;
			3'h3:    wtg_multiple = 5'h03;
			3'h4:    wtg_multiple = 5'h04;
			3'h5:    wtg_multiple = 5'h08;
			3'h6:    wtg_multiple = 5'h10;
			3'h7:    wtg_multiple = 5'h1f; // RULE10
			default: wtg_multiple = 5'h00;
		endcase
	endfunction : wtg_multiple

	always_comb begin
		first_total = {5'h00, first_listen_delay_in[`WTG_FIRST_COUNT_HI:0]} + 11'h001; // RULE9
		if (first_listen_delay_in[`WTG_FIRST_PRE_BIT]) begin
			first_total = first_total << `WTG_FIRST_PRE_SHIFT; // RULE8
		end
	end

	assign multiple     = wtg_multiple(second_listen_multiple_in);
	// both operands widened first so that 1024 x 31 does not wrap at eleven bits
	assign second_total = {5'h00, first_total} * {11'h000, multiple}; // RULE10

	// ----------------------------------------------------------------
	// listen sequence
	// ----------------------------------------------------------------
	wtg_delay_if               dly ();
	wtg_pkg::wtg_state_type    state;
	wtg_pkg::wtg_state_type    next_state;

	wtg_delay_counter u_delay (
		.clock_in  (clock_in),
		.arst_n_in (core_rst_n),
		.dly       (dly)
	);

	assign dly.tick = tick_fast; // RULE7

	always_comb begin
		next_state = state;
		dly.start  = 1'b0;
		dly.count  = `WTG_DELAY_WIDTH'(first_total);
		case (state)
			wtg_pkg::WTG_IDLE: begin
				if (wake_enable_in && period_expired_out) begin
					next_state = wtg_pkg::WTG_FIRST;
					dly.start  = 1'b1; // RULE7
				end
			end
			wtg_pkg::WTG_FIRST: begin
				if (dly.done) begin
					if (multiple == 5'h00) begin
						next_state = wtg_pkg::WTG_IDLE; // RULE11
					end else begin
						next_state = wtg_pkg::WTG_SECOND;
						dly.start  = 1'b1;
						dly.count  = second_total; // RULE10
					end
				end
			end
			wtg_pkg::WTG_SECOND: begin
				if (dly.done) begin
					next_state = wtg_pkg::WTG_IDLE;
				end
			end
			default: next_state = wtg_pkg::WTG_IDLE;
		endcase
		if (!wake_enable_in) begin
			next_state = wtg_pkg::WTG_IDLE;
			dly.start  = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge core_rst_n) begin
		if (!core_rst_n) begin
			state <= wtg_pkg::WTG_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// registered status for the listening stages
	always_ff @(posedge clock_in or negedge core_rst_n) begin
		if (!core_rst_n) begin
			first_listen_out       <= 1'b0;
			second_listen_out      <= 1'b0;
			first_done_out         <= 1'b0;
			second_done_out        <= 1'b0;
			simultaneous_check_out <= 1'b0;
		end else begin
			first_listen_out       <= (next_state == wtg_pkg::WTG_FIRST);
			second_listen_out      <= (next_state == wtg_pkg::WTG_SECOND);
			first_done_out         <= (state == wtg_pkg::WTG_FIRST) && dly.done && wake_enable_in;
			second_done_out        <= dly.done && wake_enable_in &&
				((state == wtg_pkg::WTG_SECOND) || (state == wtg_pkg::WTG_FIRST && multiple == 5'h00));
			simultaneous_check_out <= (state == wtg_pkg::WTG_FIRST) && dly.done &&
				wake_enable_in && multiple == 5'h00; // RULE11
		end
	end

	simultaneous_end_a: assert property (@(posedge clock_in) disable iff (!core_rst_n) // RULE11
		simultaneous_check_out |-> first_done_out && second_done_out && !second_listen_out)
		else $error("zero second delay did not finish both stages together");

	first_start_a: assert property (@(posedge clock_in) disable iff (!core_rst_n) // RULE7
		(state == wtg_pkg::WTG_IDLE && wake_enable_in && period_expired_out) |=> first_listen_out)
		else $error("first listen did not start on period expiry");

	long_multiple_a: assert property (@(posedge clock_in) disable iff (!core_rst_n) // RULE10
		(second_listen_multiple_in == 3'h7) |-> second_total == `WTG_DELAY_WIDTH'(first_total * 31))
		else $error("top multiple code is not 31 times");

	first_prescale_a: assert property (@(posedge clock_in) disable iff (!core_rst_n) // RULE8
		first_listen_delay_in[`WTG_FIRST_PRE_BIT] |-> first_total[3:0] == 4'h0 && first_total != 11'h000)
		else $error("first delay prescale not applied");

endmodule : wtg_wakeup_timing

`default_nettype wire

// ===== verif/wtg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "wtg_map.svh"

module wtg_host_model (
	input  wire logic                    clock_in,
	output logic [`WTG_RATE_WIDTH-1:0]   wake_rate_register_out,
	output logic [`WTG_PERIOD_WIDTH-1:0] wake_period_field_out,
	output logic [`WTG_FIRST_WIDTH-1:0]  first_listen_delay_out,
	output logic [`WTG_SECOND_WIDTH-1:0] second_listen_multiple_out
);
	initial begin
		wake_rate_register_out     = 18'h00000;
		wake_period_field_out      = 9'h000;
		first_listen_delay_out     = 7'h00;
		second_listen_multiple_out = 3'h0;
	end

	task automatic load_rate_code(input logic [`WTG_RATE_WIDTH-1:0] code);
		@(negedge clock_in);
		wake_rate_register_out = code;
	endtask : load_rate_code

	// codes for the four common wake-up bit rates
	task automatic load_rate_bps(input int bps);
		case (bps)
			1200: load_rate_code(18'h00215);
			2400: load_rate_code(18'h0010b);
			4800: load_rate_code(18'h00085);
			9600: load_rate_code(18'h00043);
			default: load_rate_code(18'h00000);
		endcase
	endtask : load_rate_bps

	task automatic load_period(input logic [`WTG_PERIOD_WIDTH-1:0] f);
		@(negedge clock_in);
		wake_period_field_out = f;
	endtask : load_period

	task automatic load_listen(input logic [`WTG_FIRST_WIDTH-1:0] f, input logic [`WTG_SECOND_WIDTH-1:0] m);
		@(negedge clock_in);
		first_listen_delay_out     = f;
		second_listen_multiple_out = m;
	endtask : load_listen
endmodule : wtg_host_model

`default_nettype wire

// ===== verif/test_wakeup_timing_generator.sv
`timescale 1ns/100ps
`default_nettype none
`include "wtg_map.svh"

module test_wakeup_timing_generator;
	localparam int SLOW = 20;
	localparam int FAST = 2;
	localparam int HZ   = 640000;
	localparam int LIM  = 20000;
	localparam int FAC [8] = '{0, 1, 2, 3, 4, 8, 16, 31};

	logic                         clock_in       = 1'b0;
	logic                         arst_n_in      = 1'b0;
	logic                         reset_write_in = 1'b0;
	logic                         wake_enable_in = 1'b0;
	logic [`WTG_RATE_WIDTH-1:0]   rate;
	logic [`WTG_PERIOD_WIDTH-1:0] period;
	logic [`WTG_FIRST_WIDTH-1:0]  first;
	logic [`WTG_SECOND_WIDTH-1:0] second;
	logic [6:0]                   outs;
	int                           err_total = 0;
	int                           tests_run = 0;

	always #10 clock_in = ~clock_in;

	wtg_host_model host_u (
		.clock_in                   (clock_in),
		.wake_rate_register_out     (rate),
		.wake_period_field_out      (period),
		.first_listen_delay_out     (first),
		.second_listen_multiple_out (second)
	);

	wtg_wakeup_timing #(.CLOCK_HZ(HZ), .TICK_SLOW_CYCLES(SLOW), .TICK_FAST_CYCLES(FAST)) dut_u (
		.clock_in                  (clock_in),
		.arst_n_in                 (arst_n_in),
		.reset_write_in            (reset_write_in),
		.wake_enable_in            (wake_enable_in),
		.wake_rate_register_in     (rate),
		.wake_period_field_in      (period),
		.first_listen_delay_in     (first),
		.second_listen_multiple_in (second),
		.rate_strobe_out           (outs[0]),
		.period_expired_out        (outs[1]),
		.first_listen_out          (outs[2]),
		.second_listen_out         (outs[3]),
		.first_done_out            (outs[4]),
		.second_done_out           (outs[5]),
		.simultaneous_check_out    (outs[6])
	);

	// ----------------------------------------------------------------
	// checking and waiting helpers
	// ----------------------------------------------------------------
	task automatic complete_run;
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	task automatic check(input bit ok, input string msg);
		tests_run++;
		if (!ok) begin
			err_total++;
			$display("unexpected at %0t ns: %s", $time, msg);
		end
	endtask : check

	function automatic bit near(input int got, input int want, input int slack);
		return got >= want - slack && got <= want + slack;
	endfunction : near

	task automatic wait_lvl(input int sel, input logic lvl, input int lim, output int n);
		n = 0;
		while (outs[sel] !== lvl && n < lim) begin
			@(negedge clock_in);
			n++;
		end
	endtask : wait_lvl

	task automatic wait_must(input int sel, input logic lvl, output int n);
		wait_lvl(sel, lvl, LIM, n);
		if (n >= LIM) begin
			err_total++;
			$display("unexpected at %0t ns: wait ran out", $time);
			complete_run();
		end
	endtask : wait_must

	// cycles from one pulse of the selected output to the next
	task automatic gap(input int sel, output int n);
		int x;
		wait_must(sel, 1'b1, x);
		@(negedge clock_in);
		wait_must(sel, 1'b1, n);
		n = n + 1;
	endtask : gap

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic rate_case(input int bps, input int code);
		int n;
		host_u.load_rate_bps(bps);
		gap(0, n);
		gap(0, n);
		check(near(n, code * (HZ / 64000), 1), "bit strobe spacing");
	endtask : rate_case

	task automatic period_case(input logic [8:0] f, input int ticks);
		int n;
		host_u.load_period(f);
		gap(1, n);
		gap(1, n);
		gap(1, n);
		check(near(n, ticks * SLOW, 1), "wake period length");
	endtask : period_case

	task automatic listen_case(input logic [6:0] f1, input logic [2:0] m, input int t1, input int mul);
		int d1;
		int d2;
		@(negedge clock_in);
		wake_enable_in = 1'b0;
		host_u.load_listen(f1, m);
		@(negedge clock_in);
		wake_enable_in = 1'b1;
		wait_must(2, 1'b1, d1);
		wait_must(2, 1'b0, d1);
		check(near(d1, t1 * FAST, 2), "first delay length");
		check(outs[4] === 1'b1, "first done missing");
		check(outs[6] === (m == 3'h0), "joint check flag");
		check(outs[5] === (m == 3'h0), "second done timing");
		check(outs[3] === (m != 3'h0), "second stage entry");
		if (m != 3'h0) begin
			wait_must(3, 1'b0, d2);
			check(near(d2, t1 * mul * FAST, 2), "second delay length");
			check(outs[5] === 1'b1, "second done missing");
		end
	endtask : listen_case

	task automatic reset_case;
		int n;
		host_u.load_listen(7'h3f, 3'h7);
		wait_must(2, 1'b1, n);
		reset_write_in = 1'b1;
		#1;
		check(outs === 7'h00, "outputs live at reset write");
		repeat (3) @(negedge clock_in);
		check(outs === 7'h00, "outputs live during reset write");
		reset_write_in = 1'b0;
	endtask : reset_case

	task automatic enable_case;
		int n;
		wait_must(2, 1'b1, n);
		wake_enable_in = 1'b0;
		@(negedge clock_in);
		check(outs[2] === 1'b0, "listen kept after disable");
		wait_lvl(1, 1'b1, 200, n);
		check(n == 200, "period ran while disabled");
		wake_enable_in = 1'b1;
	endtask : enable_case

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		repeat (8) @(negedge clock_in);
		arst_n_in = 1'b1;
		@(negedge clock_in);
		wake_enable_in = 1'b1;
		rate_case(1200, 533);
		rate_case(2400, 267);
		rate_case(4800, 133);
		rate_case(9600, 67);
		host_u.load_rate_code(18'h00000);
		wait_lvl(0, 1'b1, 2000, n);
		check(n == 2000, "strobe with code zero");
		period_case(9'h000, 1);
		period_case(9'h001, 2);
		period_case(9'h07f, 128);
		period_case(9'h081, 17);
		period_case(9'h101, 17);
		period_case(9'h102, 33);
		period_case(9'h181, 257);
		host_u.load_period(9'h000);
		listen_case(7'h00, 3'h1, 1, 1);
		listen_case(7'h3f, 3'h1, 64, 1);
		listen_case(7'h40, 3'h1, 16, 1);
		listen_case(7'h41, 3'h1, 32, 1);
		listen_case(7'h7f, 3'h1, 1024, 1);
		for (int i = 0; i < 8; i++) begin
			listen_case(7'h01, i[2:0], 2, FAC[i]);
		end
		reset_case();
		enable_case();
		complete_run();
	end
endmodule : test_wakeup_timing_generator

`default_nettype wire
